// *** rtl/loader_consts.svh ***
/*
 Constants of the port configuration field loader: word addresses,
 register indices and sizes.
 Assumes it is included once per file by bare name.
*/
`ifndef LOADER_CONSTS_SVH
`define LOADER_CONSTS_SVH

`define NUM_PORTS 6
`define MAX_PORTS 8
`define PM_WORD_BASE 8'h50
`define SLOT_WORD_BASE 8'h60
`define PORT_WORD_STRIDE 8'h02
`define PM_DATA_WORD_STEP 8'h01

// register index inside a port window (config offset in the comment)
`define REG_PM_CAP 3'h0
// 40h
`define REG_PM_CTL 3'h1
// 44h
`define REG_SLOT_CAP 3'h2
// C0h
`define REG_PORT_NUM 3'h3
// CCh
`define REG_SLOT_CLK 3'h4
// D0h
`define REG_VC_CAP 3'h5
// 144h
`define REG_TC_MAP 3'h6
// 154h
`define REG_CTRL 7'h40
`define REG_STATUS 7'h41
`define ADDR_GLOBAL_BIT 6
`define ADDR_PORT_MSB 5
`define ADDR_PORT_LSB 3
`define ADDR_REG_MSB 2

`endif

// *** rtl/loader_pkg.sv ***
/*
 Types of the port configuration field loader: states, word layouts,
 per-port field store and register images.
 Assumes loader_consts.svh holds the numeric constants.
*/
package loader_pkg;

	typedef enum logic [1:0] {ST_ISSUE, ST_WAIT, ST_READY} ld_state_t;
	typedef enum logic [1:0] {WK_PM, WK_PMDATA, WK_SLOT} word_kind_t;
	typedef enum logic [1:0] {RD_IDLE, RD_REQ, RD_REL} rd_state_t;

	typedef struct packed {
		logic [7:0] unused;
		logic [1:0] wakeEventSupport;
		logic d2Support;
		logic d1Support;
		logic [2:0] auxCurrent;
		logic noSoftReset;
	} pm_word_t;

	typedef struct packed {
		logic [7:0] pmData;
		logic [7:0] unused;
	} pm_data_word_t;

	typedef struct packed {
		logic [6:0] tcMap;
		logic [1:0] unused;
		logic [2:0] portNum;
		logic lowPriorityChannelCount;
		logic devSpecInit;
		logic slotClock;
		logic slotImpl;
	} slot_word_t;

	typedef struct packed {
		logic noSoftReset;
		logic [2:0] auxCurrent;
		logic d1Support;
		logic d2Support;
		logic [1:0] wakeEventSupport;
		logic [7:0] pmData;
		logic slotImpl;
		logic slotClock;
		logic devSpecInit;
		logic lowPriorityChannelCount;
		logic [2:0] portNum;
		logic [6:0] tcMap;
	} port_fields_t;

	typedef struct packed {
		logic [1:0] rsvdHi;
		logic [1:0] wakeEventSupport;
		logic rsvdMid;
		logic d2Support;
		logic d1Support;
		logic [2:0] auxCurrent;
		logic devSpecInit;
		logic [20:0] rsvdLo;
	} pm_cap_reg_t;

	typedef struct packed {
		logic [7:0] pmData;
		logic [19:0] rsvdMid;
		logic noSoftReset;
		logic [2:0] rsvdLo;
	} pm_ctl_reg_t;

	typedef struct packed {logic [6:0] rsvdHi; logic slotImpl; logic [23:0] rsvdLo;} slot_cap_reg_t;
	typedef struct packed {logic [4:0] rsvdHi; logic [2:0] portNum; logic [23:0] rsvdLo;} port_num_reg_t;
	typedef struct packed {logic [2:0] rsvdHi; logic slotClock; logic [27:0] rsvdLo;} slot_clk_reg_t;
	typedef struct packed {
		logic [26:0] rsvdHi;
		logic lowPriorityChannelCount;
		logic [3:0] rsvdLo;
	} vc_cap_reg_t;
	typedef struct packed {logic [23:0] rsvdHi; logic [6:0] tcMap; logic rsvdLo;} tc_map_reg_t;
	typedef struct packed {logic [30:0] rsvd; logic reload;} ctrl_reg_t;
	typedef struct packed {
		logic [24:0] rsvd;
		logic [4:0] wordCount;
		logic busy;
		logic ready;
	} status_reg_t;

endpackage : loader_pkg

// *** rtl/cfg_word_reader.sv ***
/*
 Fetches one 16-bit word from the external configuration memory with a
 four-phase request/acknowledge handshake.
 Assumes the memory holds data stable from before it raises ack until
 it sees the request drop.
*/
`timescale 1ns/1ps

module cfg_word_reader
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] addr,
	output logic memReq,
	output logic [7:0] memAddr,
	input wire logic memAck,
	input wire logic [15:0] memData,
	output logic done,
	output logic [15:0] word
);

	logic ackMeta_r;
	logic ackSync_r;
	logic [15:0] dataMeta_r;
	logic [15:0] dataSync_r;
	logic memReq_r;
	logic [7:0] memAddr_r;
	logic done_r;
	logic [15:0] word_r;
	loader_pkg::rd_state_t state_r;

	assign memReq = memReq_r;
	assign memAddr = memAddr_r;
	assign done = done_r;
	assign word = word_r;

	// data rides the same two stages as ack, so it has settled when ack is seen
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ackMeta_r <= 1'b0;
			ackSync_r <= 1'b0;
			dataMeta_r <= 16'h0000;
			dataSync_r <= 16'h0000;
		end
		else
		begin
			ackMeta_r <= memAck;
			ackSync_r <= ackMeta_r;
			dataMeta_r <= memData;
			dataSync_r <= dataMeta_r;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= loader_pkg::RD_IDLE;
			memReq_r <= 1'b0;
			memAddr_r <= 8'h00;
			done_r <= 1'b0;
			word_r <= 16'h0000;
		end
		else
		begin
			done_r <= 1'b0;
			case (state_r)
				loader_pkg::RD_IDLE:
					if (start)
					begin
						memReq_r <= 1'b1;
						memAddr_r <= addr;
						state_r <= loader_pkg::RD_REQ;
					end
				loader_pkg::RD_REQ:
					if (ackSync_r)
					begin
						word_r <= dataSync_r;
						memReq_r <= 1'b0;
						state_r <= loader_pkg::RD_REL;
					end
				loader_pkg::RD_REL:
					if (!ackSync_r)
					begin
						done_r <= 1'b1;
						state_r <= loader_pkg::RD_IDLE;
					end
				default:
					state_r <= loader_pkg::RD_IDLE;
			endcase
		end
	end

	reqHold_a: assert property (@(posedge sys_clk) disable iff (rst)
		(memReq_r && !ackSync_r) |=> (memReq_r && $stable(memAddr_r)))
		else $error("request dropped or address moved before ack");

	doneAfterRelease_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(done_r) |-> ($past(state_r) == loader_pkg::RD_REL && !memReq_r))
		else $error("word done without a completed handshake");

endmodule : cfg_word_reader

// *** rtl/port_config_field_loader.sv ***
/*
 Loads per-port configuration fields of a six-port switch from the
 external configuration memory after reset, and shows them over an
 Avalon-MM slave with waitrequest.
 Assumes one clock; memory ack and data arrive asynchronously.
*/
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "loader_consts.svh"

module port_config_field_loader
#(
	parameter int NUM_PORTS = `NUM_PORTS
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [6:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic memReq,
	output logic [7:0] memAddr,
	input wire logic memAck,
	input wire logic [15:0] memData,
	output logic cfgReady,
	output loader_pkg::port_fields_t portFields [NUM_PORTS]
);

	generate
		if (NUM_PORTS < 1 || NUM_PORTS > `MAX_PORTS)
		begin : gBadPorts
			$error("NUM_PORTS out of range");
		end
	endgenerate

	localparam logic [2:0] LAST_PORT = 3'(NUM_PORTS - 1);

	function automatic logic [7:0] wordAddr(input logic [2:0] port,
		input loader_pkg::word_kind_t kind);
		logic [7:0] offs;
		offs = 8'(port) * `PORT_WORD_STRIDE;
		if (kind == loader_pkg::WK_SLOT)
			wordAddr = `SLOT_WORD_BASE + offs;
		else if (kind == loader_pkg::WK_PMDATA)
			wordAddr = `PM_WORD_BASE + offs + `PM_DATA_WORD_STEP;
		else
			wordAddr = `PM_WORD_BASE + offs;
	endfunction : wordAddr

	function automatic logic [31:0] regImage(input loader_pkg::port_fields_t f,
		input logic [2:0] sel);
		loader_pkg::pm_cap_reg_t cap;
		loader_pkg::pm_ctl_reg_t ctl;
		loader_pkg::slot_cap_reg_t slot;
		loader_pkg::port_num_reg_t pnum;
		loader_pkg::slot_clk_reg_t sclk;
		loader_pkg::vc_cap_reg_t vc;
		loader_pkg::tc_map_reg_t tc;
		cap = '0;
		ctl = '0;
		slot = '0;
		pnum = '0;
		sclk = '0;
		vc = '0;
		tc = '0;
		cap.wakeEventSupport = f.wakeEventSupport;
		cap.d2Support = f.d2Support;
		cap.d1Support = f.d1Support;
		cap.auxCurrent = f.auxCurrent;
		cap.devSpecInit = f.devSpecInit;
		ctl.pmData = f.pmData;
		ctl.noSoftReset = f.noSoftReset;
		slot.slotImpl = f.slotImpl;
		pnum.portNum = f.portNum;
		sclk.slotClock = f.slotClock;
		vc.lowPriorityChannelCount = f.lowPriorityChannelCount;
		tc.tcMap = f.tcMap;
		if (sel == `REG_PM_CAP)
			regImage = cap;
		else if (sel == `REG_PM_CTL)
			regImage = ctl;
		else if (sel == `REG_SLOT_CAP)
			regImage = slot;
		else if (sel == `REG_PORT_NUM)
			regImage = pnum;
		else if (sel == `REG_SLOT_CLK)
			regImage = sclk;
		else if (sel == `REG_VC_CAP)
			regImage = vc;
		else if (sel == `REG_TC_MAP)
			regImage = tc;
		else
			regImage = 32'h0000_0000;
	endfunction : regImage

	loader_pkg::ld_state_t state_r;
	loader_pkg::ld_state_t state_nxt;
	loader_pkg::word_kind_t kind_r;
	logic [2:0] portIdx_r;
	logic [4:0] wordCount_r;
	logic rdStart_r;
	logic rdDone;
	logic [15:0] rdWord;
	logic waitReq_r;
	logic [31:0] readdata_r;
	logic cfgReady_r;
	loader_pkg::port_fields_t fields_r [NUM_PORTS];
	logic [31:0] readMux;

	wire loader_pkg::pm_word_t pmWord = loader_pkg::pm_word_t'(rdWord);
	wire loader_pkg::pm_data_word_t dataWord = loader_pkg::pm_data_word_t'(rdWord);
	wire loader_pkg::slot_word_t slotWord = loader_pkg::slot_word_t'(rdWord);
	wire applyEn = (state_r == loader_pkg::ST_WAIT) && rdDone;
	wire lastWord = (portIdx_r == LAST_PORT) && (kind_r == loader_pkg::WK_SLOT);
	wire busReq = read || write;
	wire accessNow = busReq && !waitReq_r;
	wire loader_pkg::ctrl_reg_t ctrlIn = loader_pkg::ctrl_reg_t'(writedata);
	wire reloadReq = accessNow && write && (address == `REG_CTRL) && ctrlIn.reload;
	wire [2:0] selPort = address[`ADDR_PORT_MSB:`ADDR_PORT_LSB];
	wire [2:0] selReg = address[`ADDR_REG_MSB:0];
	wire portWin = !address[`ADDR_GLOBAL_BIT] && (selPort <= LAST_PORT);

	assign readdata = readdata_r;
	assign waitrequest = waitReq_r;
	assign cfgReady = cfgReady_r;

	cfg_word_reader uReader
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.start(rdStart_r),
		.addr(wordAddr(portIdx_r, kind_r)),
		.memReq(memReq),
		.memAddr(memAddr),
		.memAck(memAck),
		.memData(memData),
		.done(rdDone),
		.word(rdWord)
	);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			loader_pkg::ST_ISSUE:
				state_nxt = loader_pkg::ST_WAIT;
			loader_pkg::ST_WAIT:
				if (rdDone)
					state_nxt = lastWord ? loader_pkg::ST_READY : loader_pkg::ST_ISSUE;
			loader_pkg::ST_READY:
				if (reloadReq)
					state_nxt = loader_pkg::ST_ISSUE;
			default:
				state_nxt = loader_pkg::ST_ISSUE;
		endcase
	end

	// fetch order: per port pm word, pm data word, slot word
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= loader_pkg::ST_ISSUE;
			portIdx_r <= 3'h0;
			kind_r <= loader_pkg::WK_PM;
			wordCount_r <= 5'h00;
			rdStart_r <= 1'b0;
			cfgReady_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			// taken from the present state, so the first word after reset is requested too
			rdStart_r <= (state_r == loader_pkg::ST_ISSUE);
			cfgReady_r <= (state_nxt == loader_pkg::ST_READY);
			if (reloadReq)
			begin
				portIdx_r <= 3'h0;
				kind_r <= loader_pkg::WK_PM;
				wordCount_r <= 5'h00;
			end
			else if (applyEn && !lastWord)
			begin
				wordCount_r <= wordCount_r + 5'h01;
				if (kind_r == loader_pkg::WK_PM)
					kind_r <= loader_pkg::WK_PMDATA;
				else if (kind_r == loader_pkg::WK_PMDATA)
					kind_r <= loader_pkg::WK_SLOT;
				else
				begin
					kind_r <= loader_pkg::WK_PM;
					portIdx_r <= portIdx_r + 3'h1;
				end
			end
			else if (applyEn)
				wordCount_r <= wordCount_r + 5'h01;
		end
	end

	// fields stay at their last load across a reload until overwritten
	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++)
		begin : gPort
			wire hit = applyEn && (portIdx_r == 3'(g));
			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
					fields_r[g] <= '0;
				else if (hit && kind_r == loader_pkg::WK_PM)
				begin
					fields_r[g].noSoftReset <= pmWord.noSoftReset;
					fields_r[g].auxCurrent <= pmWord.auxCurrent;
					fields_r[g].d1Support <= pmWord.d1Support;
					fields_r[g].d2Support <= pmWord.d2Support;
					fields_r[g].wakeEventSupport <= pmWord.wakeEventSupport;
				end
				else if (hit && kind_r == loader_pkg::WK_PMDATA)
					fields_r[g].pmData <= dataWord.pmData;
				else if (hit && kind_r == loader_pkg::WK_SLOT)
				begin
					fields_r[g].slotImpl <= slotWord.slotImpl;
					fields_r[g].slotClock <= slotWord.slotClock;
					fields_r[g].devSpecInit <= slotWord.devSpecInit;
					fields_r[g].lowPriorityChannelCount <= slotWord.lowPriorityChannelCount;
					fields_r[g].portNum <= slotWord.portNum;
					fields_r[g].tcMap <= slotWord.tcMap;
				end
			end
			assign portFields[g] = fields_r[g];
		end
	endgenerate

	always_comb
	begin
		loader_pkg::status_reg_t st;
		st = '0;
		st.wordCount = wordCount_r;
		st.busy = (state_r != loader_pkg::ST_READY);
		st.ready = cfgReady_r;
		if (address == `REG_STATUS)
			readMux = st;
		else if (portWin)
			readMux = regImage(fields_r[selPort], selReg);
		else
			readMux = 32'h0000_0000;
	end

	// no answer while loading, so nobody reads a half-loaded port
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			waitReq_r <= 1'b1;
			readdata_r <= 32'h0000_0000;
		end
		else
		begin
			waitReq_r <= !(busReq && waitReq_r && cfgReady_r);
			if (busReq && waitReq_r && read)
				readdata_r <= readMux;
		end
	end

	sequence pmApplySeq;
		applyEn && kind_r == loader_pkg::WK_PM;
	endsequence

	sequence slotApplySeq;
		applyEn && kind_r == loader_pkg::WK_SLOT;
	endsequence

	noSoftReset_a: assert property (@(posedge sys_clk) disable iff (rst)
		pmApplySeq |=> fields_r[$past(portIdx_r)].noSoftReset == $past(rdWord[0]))
		else $error("no-soft-reset not loaded from word bit 0");

	auxCurrent_a: assert property (@(posedge sys_clk) disable iff (rst)
		pmApplySeq |=> regImage(fields_r[$past(portIdx_r)], `REG_PM_CAP)
			== {2'b00, $past(rdWord[7:6]), 1'b0, $past(rdWord[5:4]), $past(rdWord[3:1]),
			fields_r[$past(portIdx_r)].devSpecInit, 21'h00_0000})
		else $error("capability image does not match pm word");

	pmData_a: assert property (@(posedge sys_clk) disable iff (rst)
		(applyEn && kind_r == loader_pkg::WK_PMDATA)
			|=> fields_r[$past(portIdx_r)].pmData == $past(rdWord[15:8]))
		else $error("pm data not loaded from upper byte");

	portNum_a: assert property (@(posedge sys_clk) disable iff (rst)
		slotApplySeq |=> regImage(fields_r[$past(portIdx_r)], `REG_PORT_NUM)
			== {5'h00, $past(rdWord[6:4]), 24'h00_0000})
		else $error("port number image wrong");

	tcMap_a: assert property (@(posedge sys_clk) disable iff (rst)
		slotApplySeq |=> fields_r[$past(portIdx_r)].tcMap == $past(rdWord[15:9]))
		else $error("traffic-class map not loaded");

	stallWhileLoad_a: assert property (@(posedge sys_clk) disable iff (rst)
		(!cfgReady_r && busReq) |=> waitReq_r)
		else $error("bus answered before loading finished");

	answerOneCycle_a: assert property (@(posedge sys_clk) disable iff (rst)
		(cfgReady_r && busReq && waitReq_r) |=> !waitReq_r ##1 waitReq_r)
		else $error("ready access not answered in one cycle");

	readyAfterLast_a: assert property (@(posedge sys_clk) disable iff (rst)
		(applyEn && lastWord) |=> cfgReady_r && wordCount_r == 5'(3 * NUM_PORTS))
		else $error("not ready with full count after last word");

endmodule : port_config_field_loader

// *** dv/cfg_mem_model.sv ***
/*
 Behavioural model of the external configuration memory: a 256-word
 array that answers the loader's four-phase request/acknowledge.
 Assumes the bench fills the array by hierarchical reference.
*/
`timescale 1ns/1ps

module cfg_mem_model
(
	input wire logic sys_clk,
	input wire logic memReq,
	input wire logic [7:0] memAddr,
	output logic memAck,
	output logic [15:0] memData
);
	logic [15:0] mem [256];
	logic loaded_r;
	int dly;

	initial
	begin
		memAck = 1'b0;
		memData = 16'hA5A5;
		loaded_r = 1'b0;
		dly = 0;
	end

	// data settles a cycle before ack rises; random delay mixes prompt and slow answers
	always @(posedge sys_clk)
	begin
		if (memReq && !memAck)
		begin
			if (dly > 0)
				dly <= dly - 1;
			else if (!loaded_r)
			begin
				memData <= mem[memAddr];
				loaded_r <= 1'b1;
			end
			else
				memAck <= 1'b1;
		end
		else if (!memReq && memAck)
		begin
			// released bus shows the inverse, so a late sample cannot pass
			memAck <= 1'b0;
			memData <= ~memData;
			loaded_r <= 1'b0;
			dly <= $urandom_range(5);
		end
	end
endmodule : cfg_mem_model

// *** dv/port_config_field_loader_test.sv ***
/*
 Self-checking bench of the port configuration field loader: loads
 random words, reads every field register over Avalon-MM, then reloads.
 Assumes the memory model in cfg_mem_model.sv and the design constants.
*/
`timescale 1ns/1ps
`include "loader_consts.svh"

module port_config_field_loader_test;
	logic sys_clk, rst, read, write, memReq, memAck, waitrequest, cfgReady;
	logic [6:0] address;
	logic [31:0] writedata, readdata;
	logic [7:0] memAddr;
	logic [15:0] memData;
	loader_pkg::port_fields_t portFields [`NUM_PORTS];
	logic [31:0] expQ [$];
	int n_fail, comparisons;
	logic memReqOld = 1'b0;
	int fetchIdx = 0;

	port_config_field_loader #(.NUM_PORTS(`NUM_PORTS)) uut
	(
		.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memData(memData),
		.cfgReady(cfgReady), .portFields(portFields)
	);

	cfg_mem_model mem_i
	(
		.sys_clk(sys_clk), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
		.memData(memData)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	// index 7 gives the per-port field store image
	function automatic logic [31:0] regExp(input int p, input int r);
		logic [15:0] pm, pd, sl;
		pm = mem_i.mem[`PM_WORD_BASE + 2 * p];
		pd = mem_i.mem[`PM_WORD_BASE + 2 * p + 1];
		sl = mem_i.mem[`SLOT_WORD_BASE + 2 * p];
		case (r)
			0: return {2'h0, pm[7:6], 1'b0, pm[5], pm[4], pm[3:1], sl[2], 21'h0};
			1: return {pd[15:8], 20'h0, pm[0], 3'h0};
			2: return {7'h0, sl[0], 24'h0};
			3: return {5'h0, sl[6:4], 24'h0};
			4: return {3'h0, sl[1], 28'h0};
			5: return {27'h0, sl[3], 4'h0};
			6: return {24'h0, sl[15:9], 1'b0};
			default: return {2'h0, pm[0], pm[3:1], pm[4], pm[5], pm[7:6], pd[15:8],
				sl[0], sl[1], sl[2], sl[3], sl[6:4], sl[15:9]};
		endcase
	endfunction : regExp

	// load order per port: pm word, pm data word, slot word
	function automatic logic [31:0] fetchAddr(input int n);
		if (n % 3 == 2)
			return `SLOT_WORD_BASE + 2 * (n / 3);
		return `PM_WORD_BASE + 2 * (n / 3) + n % 3;
	endfunction : fetchAddr

	// port 0 all ones and port 1 all zeros catch stuck field bits
	task automatic fill(input bit corner);
		int a;
		for (a = 0; a < 256; a++)
			mem_i.mem[a] = 16'($urandom);
		for (a = 0; a < 2 && corner; a++)
		begin
			mem_i.mem[`PM_WORD_BASE + a] = 16'hFFFF;
			mem_i.mem[`PM_WORD_BASE + 2 + a] = 16'h0000;
			mem_i.mem[`SLOT_WORD_BASE + 2 * a] = a ? 16'h0000 : 16'hFFFF;
		end
	endtask : fill

	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
		int i;
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		for (i = 0; i < 5000; i++)
		begin
			@(posedge sys_clk);
			if (waitrequest === 1'b0)
				break;
		end
		if (i == 5000)
		begin
			n_fail++;
			end_sim();
		end
		read <= 1'b0;
		write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	// every new memory request must name the next word of the load order
	always @(posedge sys_clk)
	begin
		memReqOld <= memReq;
		if (memReq && !memReqOld)
		begin
			check({24'h0, memAddr}, fetchAddr(fetchIdx));
			fetchIdx <= (fetchIdx + 1) % (3 * `NUM_PORTS);
		end
	end

	// read answers must never come before the load has finished
	always @(posedge sys_clk)
	begin
		if (read && waitrequest === 1'b0)
		begin
			check({31'h0, cfgReady}, 32'h1);
			check(readdata, expQ.pop_front());
		end
	end

	initial
	begin
		int it, p, r;
		void'($urandom(32'h4e29));
		rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 7'h00;
		writedata = 32'h0;
		n_fail = 0;
		comparisons = 0;
		fill(1'b0);
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		for (it = 0; it < 2; it++)
		begin
			if (it == 1)
			begin
				fill(1'b1);
				bus(1'b1, `REG_CTRL, 32'h1);
			end
			// issued while loading, so it stalls until every word is in
			expQ.push_back({25'h0, 5'(3 * `NUM_PORTS), 2'b01});
			bus(1'b0, `REG_STATUS, $urandom);
			for (p = 0; p < `NUM_PORTS; p++)
			begin
				check({2'h0, portFields[p]}, regExp(p, 7));
				for (r = 0; r < 7; r++)
				begin
					expQ.push_back(regExp(p, r));
					bus(1'b0, 7'(p * 8 + r), $urandom);
				end
			end
			for (r = 0; r < 3; r++)
			begin
				expQ.push_back(32'h0);
				bus(1'b0, r == 0 ? 7'h07 : r == 1 ? 7'h30 : 7'h7F, $urandom);
			end
			for (r = 0; r < 2; r++)
			begin
				bus(1'b1, 7'(16 + r), 32'hFFFFFFFF);
				expQ.push_back(regExp(2, r));
				bus(1'b0, 7'(16 + r), $urandom);
			end
		end
		end_sim();
	end
endmodule : port_config_field_loader_test
